//--- rtl/lab_pkg.sv
// Package: offsets, field positions, codes and carrier types of the LIU alarm bank
package lab_pkg;
	// ==========================================================
	// Register offsets (primary bank unless noted)
	localparam logic [4:0] OFS_CRIT = 5'h0d;
	localparam logic [4:0] OFS_GCFG = 5'h0f;
	localparam logic [4:0] OFS_TPTR = 5'h10;
	localparam logic [4:0] OFS_TPL = 5'h11;
	localparam logic [4:0] OFS_OED = 5'h12;
	localparam logic [4:0] OFS_AIS = 5'h13;
	localparam logic [4:0] OFS_AIE = 5'h14;
	localparam logic [4:0] OFS_AIF = 5'h15;
	localparam logic [4:0] OFS_IRQCFG = 5'h1e;
	localparam logic [4:0] OFS_BANK = 5'h1f;
	localparam logic [4:0] OFS_JA_CHAN = 5'h00; // Individual bank
	// ==========================================================
	// Bank pointer codes
	localparam logic [7:0] BANK_PRI = 8'h00;
	localparam logic [7:0] BANK_SEC = 8'haa;
	localparam logic [7:0] BANK_IND = 8'h01;
	localparam logic [7:0] BANK_BERT = 8'h02;
	// ==========================================================
	// Field positions and constants
	localparam int GCFG_JA_ALL_BIT = 0;
	localparam int IRQCFG_COW_BIT = 0;
	localparam int TPL_RXOFF_BIT = 7;
	localparam int TPL_TXOFF_BIT = 6;
	localparam int TPL_OHM_BIT = 3;
	localparam int TPL_CODE_W = 3;
	localparam int TPTR_W = 3;
	localparam int CHAN_N = 8;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [2:0] TPL_E1 = 3'h0;
	localparam logic [2:0] TPL_T1_SHORT = 3'h3;
	localparam logic [2:0] TPL_RSV_LO = 3'h1;
	localparam logic [2:0] TPL_RSV_HI = 3'h2;
	localparam logic VARIANT_120 = 1'b1; // 1: 120-ohm default part
	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		LAB_OHM_120 = 4'h1,
		LAB_OHM_100 = 4'h2,
		LAB_OHM_75 = 4'h4,
		LAB_OHM_110 = 4'h8
	} lab_ohm_t;
	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} lab_bus_t;
	typedef struct packed {
		logic rx_match_off;
		logic tx_termination_off;
		logic impedance_choice;
		logic [2:0] template_code;
	} lab_tpl_t;
	typedef struct packed {
		logic e1;
		logic t1;
		logic reserved;
		lab_ohm_t ohm;
		lab_tpl_t tpl;
	} lab_chan_t;
	typedef struct packed {
		logic [7:0] crit;
		logic [7:0] gcfg;
		logic [TPTR_W-1:0] ptr;
		lab_tpl_t [7:0] tpl;
		logic [7:0] oed;
		logic [7:0] alarm_indication_status;
		logic [7:0] aie;
		logic [7:0] aif;
		logic [7:0] irqcfg;
		logic [7:0] bank;
		logic [7:0] ja_chan;
		logic [7:0] rdata;
		logic irq;
		logic [7:0] tx_hiz;
		logic [7:0] ja_en;
		lab_chan_t [7:0] chan;
	} lab_state_t;
endpackage

//--- rtl/lab_regs.sv
// Register bank of the eight-channel LIU: templates, output disable, alarms, banks
//
// Summary of operation
// - Global jitter enable forces all channels on, else per-channel enables govern.
// - Three-bit pointer picks the channel the template register 11h acts on.
// - Template bit 7 set switches off receive impedance matching.
// - Template bit 6 set switches off internal transmit termination.
// - Bit 3 picks termination/match ohms; in E1 its meaning depends on part variant.
// - Three-bit code picks E1, T1/J1 short, longer T1 ranges; 001/010 reserved.
// - Output disable bit set puts that channel's transmitter in high impedance.
// - Output-enable pin low overrides the per-channel disable register.
// - Alarm status bit follows detection using per-channel criteria select.
// - Channel interrupt allowed only while its enable bit is one.
// - Flag bit latches on every alarm status transition, both directions.
// - With clear-on-write off, reading the flag register clears flags.
// - With clear-on-write on, writing a one clears a flag; reads keep it.
// - Bank pointer at 1Fh selects primary, secondary, individual or BERT bank.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module lab_regs (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire lab_pkg::lab_bus_t bus_i,
	output logic [7:0] rdata_o,
	// Line side
	input wire logic [7:0] alarm_det_i,
	input wire logic oe_pin_i,
	output logic [7:0] loss_alarm_criteria_select_o,
	output logic [7:0] jitter_atten_en_o,
	output logic [7:0] tx_hiz_o,
	output lab_pkg::lab_chan_t [7:0] chan_cfg_o,
	// Interrupt
	output logic irq_o
);

	// ==========================================================
	// Helpers

	// Decode one channel's template setting
	function automatic lab_pkg::lab_chan_t chan_decode(input lab_pkg::lab_tpl_t t);
		lab_pkg::lab_chan_t c;
		c.tpl = t;
		c.e1 = (t.template_code == lab_pkg::TPL_E1);
		c.reserved = (t.template_code == lab_pkg::TPL_RSV_LO)
			|| (t.template_code == lab_pkg::TPL_RSV_HI);
		c.t1 = !c.e1 && !c.reserved;
		// Ohm choice by mode, variant and bit 3
		if (c.e1) begin
			c.ohm = (t.impedance_choice ^ !lab_pkg::VARIANT_120)
				? lab_pkg::LAB_OHM_75 : lab_pkg::LAB_OHM_120;
		end else begin
			c.ohm = t.impedance_choice ? lab_pkg::LAB_OHM_110 : lab_pkg::LAB_OHM_100;
		end
		return c;
	endfunction

	// Access hits an offset in a given bank
	function automatic logic hit(input logic [7:0] bank, input logic [7:0] want,
			input logic [4:0] addr, input logic [4:0] ofs);
		return (bank == want) && (addr == ofs);
	endfunction

	// Pack a template entry into register layout; bits 5:4 read zero
	function automatic logic [7:0] tpl_pack(input lab_pkg::lab_tpl_t t);
		logic [7:0] v;
		v = lab_pkg::RST_BYTE;
		v[lab_pkg::TPL_RXOFF_BIT] = t.rx_match_off;
		v[lab_pkg::TPL_TXOFF_BIT] = t.tx_termination_off;
		v[lab_pkg::TPL_OHM_BIT] = t.impedance_choice;
		v[lab_pkg::TPL_CODE_W-1:0] = t.template_code;
		return v;
	endfunction

	// ==========================================================
	// State

	// Whole module state, registered as one word
	lab_pkg::lab_state_t s_reg;
	lab_pkg::lab_state_t s_next;
	// Template value carried by the current write data
	lab_pkg::lab_tpl_t tpl_wr_val;
	// Flag bits that software clears this cycle
	logic [7:0] aif_clr;
	// Status bits that change this cycle
	logic [7:0] ais_chg;
	// Write-one-to-clear mode selected
	logic cow_on;
	// Strobes decoded against the primary bank
	logic pri_wr;
	logic pri_rd;

	// Next-state logic
	always_comb begin
		s_next = s_reg;
		// Template value carried by write data
		tpl_wr_val.rx_match_off = bus_i.wdata[lab_pkg::TPL_RXOFF_BIT];
		tpl_wr_val.tx_termination_off = bus_i.wdata[lab_pkg::TPL_TXOFF_BIT];
		tpl_wr_val.impedance_choice = bus_i.wdata[lab_pkg::TPL_OHM_BIT];
		tpl_wr_val.template_code = bus_i.wdata[lab_pkg::TPL_CODE_W-1:0];
		cow_on = s_reg.irqcfg[lab_pkg::IRQCFG_COW_BIT];
		pri_wr = bus_i.wr && (s_reg.bank == lab_pkg::BANK_PRI);
		pri_rd = bus_i.rd && (s_reg.bank == lab_pkg::BANK_PRI);
		// Bank pointer always reachable
		if (bus_i.wr && (bus_i.addr == lab_pkg::OFS_BANK)) begin
			s_next.bank = bus_i.wdata;
		end
		// Primary bank writes
		if (pri_wr) begin
			unique case (bus_i.addr)
				lab_pkg::OFS_CRIT: s_next.crit = bus_i.wdata;
				lab_pkg::OFS_GCFG: s_next.gcfg = bus_i.wdata;
				lab_pkg::OFS_TPTR: s_next.ptr = bus_i.wdata[lab_pkg::TPTR_W-1:0];
				lab_pkg::OFS_TPL: s_next.tpl[s_reg.ptr] = tpl_wr_val;
				lab_pkg::OFS_OED: s_next.oed = bus_i.wdata;
				lab_pkg::OFS_AIE: s_next.aie = bus_i.wdata;
				lab_pkg::OFS_IRQCFG: s_next.irqcfg = bus_i.wdata;
				default: ;
			endcase
		end
		// Individual bank writes
		if (bus_i.wr && hit(s_reg.bank, lab_pkg::BANK_IND, bus_i.addr, lab_pkg::OFS_JA_CHAN)) begin
			s_next.ja_chan = bus_i.wdata;
		end
		// Alarm status and transition flags; set wins over clear
		s_next.alarm_indication_status = alarm_det_i;
		ais_chg = alarm_det_i ^ s_reg.alarm_indication_status;
		aif_clr = lab_pkg::RST_BYTE;
		if (cow_on && pri_wr && (bus_i.addr == lab_pkg::OFS_AIF)) begin
			aif_clr = bus_i.wdata;
		end
		if (!cow_on && pri_rd && (bus_i.addr == lab_pkg::OFS_AIF)) begin
			aif_clr = lab_pkg::ALL_ONES;
		end
		s_next.aif = (s_reg.aif & ~aif_clr) | ais_chg;
		s_next.irq = |(s_next.aif & s_next.aie);
		// Transmitter high impedance; pin low disables all
		s_next.tx_hiz = oe_pin_i ? s_next.oed : lab_pkg::ALL_ONES;
		// Jitter attenuator enables
		s_next.ja_en = s_next.gcfg[lab_pkg::GCFG_JA_ALL_BIT]
			? lab_pkg::ALL_ONES : s_next.ja_chan;
		// Per-channel template outputs
		for (int i = 0; i < lab_pkg::CHAN_N; i++) begin
			s_next.chan[i] = chan_decode(s_next.tpl[i]);
		end
		// Read data, one cycle after the strobe
		s_next.rdata = lab_pkg::RST_BYTE;
		if (bus_i.rd) begin
			if (bus_i.addr == lab_pkg::OFS_BANK) begin
				s_next.rdata = s_reg.bank;
			end else if (hit(s_reg.bank, lab_pkg::BANK_IND, bus_i.addr, lab_pkg::OFS_JA_CHAN)) begin
				s_next.rdata = s_reg.ja_chan;
			end else if (pri_rd) begin
				unique case (bus_i.addr)
					lab_pkg::OFS_CRIT: s_next.rdata = s_reg.crit;
					lab_pkg::OFS_GCFG: s_next.rdata = s_reg.gcfg;
					lab_pkg::OFS_TPTR: s_next.rdata = {5'h00, s_reg.ptr};
					lab_pkg::OFS_TPL: s_next.rdata = tpl_pack(s_reg.tpl[s_reg.ptr]);
					lab_pkg::OFS_OED: s_next.rdata = s_reg.oed;
					lab_pkg::OFS_AIS: s_next.rdata = s_reg.alarm_indication_status;
					lab_pkg::OFS_AIE: s_next.rdata = s_reg.aie;
					lab_pkg::OFS_AIF: s_next.rdata = s_reg.aif;
					lab_pkg::OFS_IRQCFG: s_next.rdata = s_reg.irqcfg;
					default: s_next.rdata = lab_pkg::RST_BYTE;
				endcase
			end
		end
	end

	// State register, synchronous reset
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
			s_reg.tx_hiz <= lab_pkg::ALL_ONES;
			for (int i = 0; i < lab_pkg::CHAN_N; i++) begin
				s_reg.chan[i].e1 <= 1'b1;
				s_reg.chan[i].ohm <= lab_pkg::VARIANT_120
					? lab_pkg::LAB_OHM_120 : lab_pkg::LAB_OHM_75;
			end
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from state
	assign rdata_o = s_reg.rdata;
	assign loss_alarm_criteria_select_o = s_reg.crit;
	assign jitter_atten_en_o = s_reg.ja_en;
	assign tx_hiz_o = s_reg.tx_hiz;
	assign chan_cfg_o = s_reg.chan;
	assign irq_o = s_reg.irq;

	// ==========================================================
	// Checks

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Template write through the pointer
	sequence tpl_write;
		bus_i.wr && (s_reg.bank == lab_pkg::BANK_PRI) && (bus_i.addr == lab_pkg::OFS_TPL);
	endsequence

	// Bank pointer write selecting the individual bank
	sequence bank_to_ind;
		bus_i.wr && (bus_i.addr == lab_pkg::OFS_BANK) && (bus_i.wdata == lab_pkg::BANK_IND);
	endsequence

	// Bank switch, one idle cycle, then write of the first individual register
	sequence ind_write;
		bank_to_ind ##1 !bus_i.wr
		##1 (bus_i.wr && (bus_i.addr == lab_pkg::OFS_JA_CHAN));
	endsequence

	// Flag read with no new transition
	sequence flag_read_quiet;
		bus_i.rd && (s_reg.bank == lab_pkg::BANK_PRI) && (bus_i.addr == lab_pkg::OFS_AIF)
		&& !bus_i.wr && (alarm_det_i == s_reg.alarm_indication_status);
	endsequence

	// Flag read while a status bit moves
	sequence flag_read_busy;
		bus_i.rd && (s_reg.bank == lab_pkg::BANK_PRI) && (bus_i.addr == lab_pkg::OFS_AIF)
		&& (alarm_det_i != s_reg.alarm_indication_status);
	endsequence

	// Flag write with no new transition
	sequence flag_write_quiet;
		bus_i.wr && (s_reg.bank == lab_pkg::BANK_PRI) && (bus_i.addr == lab_pkg::OFS_AIF)
		&& (alarm_det_i == s_reg.alarm_indication_status);
	endsequence

	// Read in a bank that holds nothing here
	sequence empty_bank_read;
		bus_i.rd && (bus_i.addr != lab_pkg::OFS_BANK)
		&& (s_reg.bank != lab_pkg::BANK_PRI) && (s_reg.bank != lab_pkg::BANK_IND);
	endsequence

	chk_jitter_global: assert property (
		s_reg.ja_en == (s_reg.gcfg[lab_pkg::GCFG_JA_ALL_BIT] ? lab_pkg::ALL_ONES : s_reg.ja_chan))
		else $error("jitter enable mismatch");

	// Stored entry and its decoded copy both land at the write edge
	chk_tpl_pointer: assert property (
		tpl_write |=> (s_reg.tpl[$past(s_reg.ptr)] == $past(tpl_wr_val))
			&& (s_reg.chan[$past(s_reg.ptr)].tpl == $past(tpl_wr_val)))
		else $error("template write missed pointed channel");

	chk_hiz_register: assert property (
		oe_pin_i |=> s_reg.tx_hiz == s_reg.oed)
		else $error("output disable not applied");

	chk_hiz_pin: assert property (
		!oe_pin_i |=> s_reg.tx_hiz == lab_pkg::ALL_ONES)
		else $error("pin override not applied");

	chk_status_follow: assert property (
		##1 s_reg.alarm_indication_status == $past(alarm_det_i))
		else $error("alarm status lags detection");

	chk_flag_latch: assert property (
		(alarm_det_i != s_reg.alarm_indication_status) |=> ((s_reg.aif & $past(ais_chg)) == $past(ais_chg)))
		else $error("transition flag not latched");

	chk_read_clear: assert property (
		(flag_read_quiet and !cow_on) |=> s_reg.aif == lab_pkg::RST_BYTE)
		else $error("read did not clear flags");

	// A transition at the clearing read keeps its flag
	chk_read_set_wins: assert property (
		(flag_read_busy and !cow_on) |=> s_reg.aif == $past(ais_chg))
		else $error("transition lost at clearing read");

	chk_read_keep: assert property (
		(flag_read_quiet and cow_on) |=> s_reg.aif == $past(s_reg.aif))
		else $error("read changed flags in write-clear mode");

	// Only the bits written as one are cleared
	chk_write_clear: assert property (
		(flag_write_quiet and cow_on)
		|=> s_reg.aif == ($past(s_reg.aif) & ~$past(bus_i.wdata)))
		else $error("write-one-to-clear wrong");

	chk_irq_level: assert property (
		s_reg.irq == |(s_reg.aif & s_reg.aie))
		else $error("interrupt level wrong");

	chk_irq_masked: assert property (
		(s_reg.aie == lab_pkg::RST_BYTE) |-> !s_reg.irq)
		else $error("interrupt with all enables off");

	chk_bank_switch: assert property (
		ind_write |=> s_reg.ja_chan == $past(bus_i.wdata) && s_reg.bank == lab_pkg::BANK_IND)
		else $error("individual bank write lost");

	// Secondary and test banks read as zero in this block
	chk_bank_empty: assert property (
		empty_bank_read |=> s_reg.rdata == lab_pkg::RST_BYTE)
		else $error("empty bank read not zero");

	// Per-channel decode of the stored template
	for (genvar g = 0; g < lab_pkg::CHAN_N; g++) begin : g_chan
		chk_mode_decode: assert property (
			(s_reg.chan[g].e1 == (s_reg.tpl[g].template_code == lab_pkg::TPL_E1))
			&& (s_reg.chan[g].reserved == ((s_reg.tpl[g].template_code == lab_pkg::TPL_RSV_LO)
				|| (s_reg.tpl[g].template_code == lab_pkg::TPL_RSV_HI)))
			&& (s_reg.chan[g].t1 == !(s_reg.chan[g].e1 || s_reg.chan[g].reserved)))
			else $error("template mode decode wrong");

		chk_term_bits: assert property (
			(s_reg.chan[g].tpl.rx_match_off == s_reg.tpl[g].rx_match_off)
			&& (s_reg.chan[g].tpl.tx_termination_off == s_reg.tpl[g].tx_termination_off))
			else $error("termination off bits not carried");

		// Variant fixed at 120 ohm default: bit 3 picks 75 in E1, 110 in T1
		chk_ohm_choice: assert property (
			s_reg.chan[g].ohm == (s_reg.chan[g].e1
				? (s_reg.tpl[g].impedance_choice ? lab_pkg::LAB_OHM_75 : lab_pkg::LAB_OHM_120)
				: (s_reg.tpl[g].impedance_choice ? lab_pkg::LAB_OHM_110 : lab_pkg::LAB_OHM_100)))
			else $error("impedance choice wrong");
	end

endmodule // lab_regs

`default_nettype wire

//--- tb/lab_tb.sv
// Self-checking testbench of the LIU register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ==========================================================
	// Stimulus, observed outputs and bookkeeping
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	lab_pkg::lab_bus_t bus_i = '0;
	logic [7:0] alarm_det_i = 8'h00;
	logic oe_pin_i = 1'b1;
	logic [7:0] rdata_o, crit_o, jitter_atten_en_o, tx_hiz_o;
	lab_pkg::lab_chan_t [7:0] chan_cfg_o;
	logic irq_o;
	logic [7:0] d;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	lab_regs u_lab_regs (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
		.rdata_o(rdata_o), .alarm_det_i(alarm_det_i), .oe_pin_i(oe_pin_i),
		.loss_alarm_criteria_select_o(crit_o), .jitter_atten_en_o(jitter_atten_en_o),
		.tx_hiz_o(tx_hiz_o), .chan_cfg_o(chan_cfg_o), .irq_o(irq_o));
	// 25 MHz clock
	always #20 ref_clk_i = ~ref_clk_i;
	// Watchdog against a hung run
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails = fails + 1;
			conclude();
		end
	end
	// ==========================================================
	// Bus and compare helpers
	task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count = check_count + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		bus_i.addr <= a;
		bus_i.wdata <= v;
		bus_i.wr <= 1'b1;
		@(posedge ref_clk_i);
		bus_i.wr <= 1'b0;
	endtask
	task automatic rdc(input string what, input logic [4:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		bus_i.addr <= a;
		bus_i.rd <= 1'b1;
		@(posedge ref_clk_i);
		bus_i.rd <= 1'b0;
		#1 d = rdata_o;
		cmp8(what, e, d);
	endtask
	task automatic settle;
		@(posedge ref_clk_i);
		#1;
	endtask
	// ==========================================================
	// Scenarios
	task automatic test_reset;
		logic [4:0] ofs [7] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1f};
		foreach (ofs[i]) rdc("reset value", ofs[i], 8'h00);
		settle();
		cmp8("rdata idle", 8'h00, rdata_o);
		cmp8("hiz reset", 8'h00, tx_hiz_o);
		cmp8("irq reset", 8'h00, {7'h0, irq_o});
		$display("test done: reset");
	endtask
	task automatic test_template;
		logic [5:0] t;
		for (int c = 0; c < 8; c++) begin
			t = {c[0], c[1], c[2], c[2:0]};
			wr(5'h10, 8'(c));
			wr(5'h11, {t[5:4], 2'b00, t[3:0]});
			settle();
			cmp8("tpl", {2'h0, t}, {2'h0, chan_cfg_o[c].tpl});
			cmp8("mode", {5'h0, c == 0, c > 2, c == 1 || c == 2}, {5'h0, chan_cfg_o[c].e1,
				chan_cfg_o[c].t1, chan_cfg_o[c].reserved});
		end
		cmp8("ohm e1", {4'h0, lab_pkg::LAB_OHM_120}, {4'h0, chan_cfg_o[0].ohm});
		cmp8("ohm t1", {4'h0, lab_pkg::LAB_OHM_100}, {4'h0, chan_cfg_o[3].ohm});
		cmp8("ohm t1 alt", {4'h0, lab_pkg::LAB_OHM_110}, {4'h0, chan_cfg_o[4].ohm});
		wr(5'h10, 8'h00);
		wr(5'h11, 8'h38);
		settle();
		cmp8("ohm e1 alt", {4'h0, lab_pkg::LAB_OHM_75}, {4'h0, chan_cfg_o[0].ohm});
		cmp8("ch8 kept", 8'h3f, {2'h0, chan_cfg_o[7].tpl});
		rdc("tpl readback", 5'h11, 8'h08);
		wr(5'h10, 8'hff);
		rdc("ptr readback", 5'h10, 8'h07);
		$display("test done: template");
	endtask
	task automatic test_outputs;
		wr(5'h12, 8'ha5);
		settle();
		cmp8("hiz reg", 8'ha5, tx_hiz_o);
		@(posedge ref_clk_i);
		oe_pin_i <= 1'b0;
		settle();
		settle();
		cmp8("hiz pin", 8'hff, tx_hiz_o);
		@(posedge ref_clk_i);
		oe_pin_i <= 1'b1;
		wr(5'h13, 8'hff);
		rdc("status ro", 5'h13, 8'h00);
		cmp8("hiz back", 8'ha5, tx_hiz_o);
		wr(5'h0d, 8'h5a);
		settle();
		cmp8("criteria", 8'h5a, crit_o);
		$display("test done: outputs");
	endtask
	task automatic test_banks;
		rdc("pri 00", 5'h00, 8'h00);
		wr(5'h1f, 8'h01);
		wr(5'h00, 8'h3c);
		settle();
		cmp8("ja ind", 8'h3c, jitter_atten_en_o);
		rdc("ind rd", 5'h00, 8'h3c);
		wr(5'h1f, 8'haa);
		rdc("sec rd", 5'h00, 8'h00);
		wr(5'h1f, 8'h02);
		rdc("bert rd", 5'h00, 8'h00);
		rdc("ptr rd", 5'h1f, 8'h02);
		wr(5'h1f, 8'h00);
		wr(5'h0f, 8'h01);
		settle();
		cmp8("ja glob", 8'hff, jitter_atten_en_o);
		wr(5'h0f, 8'h00);
		settle();
		cmp8("ja back", 8'h3c, jitter_atten_en_o);
		$display("test done: banks");
	endtask
	task automatic test_alarm;
		wr(5'h14, 8'h01);
		alarm_det_i <= 8'h03;
		repeat (2) settle();
		cmp8("irq set", 8'h01, {7'h0, irq_o});
		rdc("status", 5'h13, 8'h03);
		rdc("flag rd", 5'h15, 8'h03);
		rdc("flag clr", 5'h15, 8'h00);
		cmp8("irq clr", 8'h00, {7'h0, irq_o});
		@(posedge ref_clk_i);
		alarm_det_i <= 8'h01;
		repeat (2) settle();
		cmp8("irq masked", 8'h00, {7'h0, irq_o});
		rdc("flag fall", 5'h15, 8'h02);
		wr(5'h1e, 8'h01);
		alarm_det_i <= 8'h00;
		repeat (2) settle();
		rdc("cow rd", 5'h15, 8'h01);
		rdc("cow keep", 5'h15, 8'h01);
		cmp8("irq cow", 8'h01, {7'h0, irq_o});
		wr(5'h15, 8'h01);
		rdc("cow clr", 5'h15, 8'h00);
		cmp8("irq off", 8'h00, {7'h0, irq_o});
		$display("test done: alarm");
	endtask
	// ==========================================================
	// Closing report
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		test_reset();
		test_template();
		test_outputs();
		test_banks();
		test_alarm();
		conclude();
	end
endmodule // testbench
`default_nettype wire
